// *** hdl/iom_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-group, eight-line vectored interrupt controller option logic
module iom_ctrl
  import iom_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [15:0] irq_pin,
  input  wire logic [1:0]  soft_reset,
  input  wire logic [1:0]  option_wr,
  input  wire logic [7:0]  option_wdata,
  input  wire logic [1:0]  mask_wr,
  input  wire logic [7:0]  mask_wdata,
  input  wire logic [1:0]  autoclear_wr,
  input  wire logic [7:0]  autoclear_wdata,
  input  wire logic [1:0]  latch_clr,
  input  wire logic [7:0]  latch_clr_bits,
  input  wire logic [1:0]  service_clr,
  input  wire logic [7:0]  service_clr_bits,
  input  wire logic        vec_wr,
  input  wire logic [3:0]  vec_waddr,
  input  wire logic [7:0]  vec_wdata,
  input  wire logic        ack_cycle,
  output logic [7:0]       vector_out,
  output logic             vector_valid,
  output logic             vector_group,
  output logic [1:0]       group_irq_out,
  output logic             bus_irq_level4,
  output logic [7:0]       group1_data_port,
  output logic [7:0]       group2_data_port,
  output logic [1:0]       prio_mode_status,
  output logic [1:0]       poll_mode_status,
  output logic [1:0]       arm_status,
  output logic [1:0]       pending_status
);

  // Request pins: two-stage synchroniser, then a history stage for edges
  logic [15:0] pin_meta;
  logic [15:0] pin_sync;
  logic [15:0] pin_prev;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
      pin_prev <= 16'h0000;
    end else begin
      pin_meta <= irq_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Vector memory, one byte per line per group
  logic [7:0] vec_mem [16];

  always_ff @(posedge core_clk) begin
    if (vec_wr) begin
      vec_mem[vec_waddr] <= vec_wdata;
    end
  end

  // Per-group state
  logic [7:0] option_reg    [GROUPS];
  logic [7:0] request_latch [GROUPS];
  logic [7:0] in_service_bits [GROUPS];
  logic [7:0] mask_bits     [GROUPS];
  logic [7:0] autoclear_bits [GROUPS];
  logic [2:0] rot_last      [GROUPS];
  logic [2:0] cur_sel       [GROUPS];
  logic [7:0] data_port     [GROUPS];

  // Per-group combinational terms
  logic [7:0] eligible [GROUPS];
  logic [1:0] grp_hit;
  logic [2:0] grp_idx  [GROUPS];
  logic [1:0] armed;
  logic [1:0] take;

  // Acknowledge resolution between groups
  logic       ack_take;
  logic       ack_grp;
  logic [2:0] ack_idx;

  // Group one always outranks group two, rotation never crosses groups
  assign ack_grp  = ~grp_hit[0];
  assign ack_idx  = grp_hit[0] ? grp_idx[0] : grp_idx[1];
  assign ack_take = ack_cycle & (|grp_hit);
  assign take[0]  = ack_take & ~ack_grp;
  assign take[1]  = ack_take & ack_grp;

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : grp
      logic       prio_mode_bit;
      logic       vector_mode_bit;
      logic       poll_mode_bit;
      logic       req_polarity_bit;
      logic       read_select_low;
      logic       read_select_high;
      logic       group_arm_bit;
      logic       grp_reset;
      logic [7:0] now_lvl;
      logic [7:0] was_lvl;
      logic [7:0] edge_set;
      logic [7:0] fence_ok;
      logic [7:0] svc_set;
      logic [7:0] svc_clr;
      logic [7:0] next_svc;
      logic [2:0] top_pos;
      logic [2:0] cur_idx_for_take;

      assign prio_mode_bit    = option_reg[g][PRIO_MODE_POS];
      assign vector_mode_bit  = option_reg[g][VECTOR_MODE_POS];
      assign poll_mode_bit    = option_reg[g][POLL_MODE_POS];
      assign req_polarity_bit = option_reg[g][POLARITY_POS];
      assign read_select_low  = option_reg[g][RD_SEL_LOW_POS];
      assign read_select_high = option_reg[g][RD_SEL_HIGH_POS];
      assign group_arm_bit    = option_reg[g][ARM_POS];
      assign grp_reset        = srst | soft_reset[g];

      // Option register; bit three is stored as written, nothing reads it
      always_ff @(posedge core_clk) begin
        if (grp_reset) begin
          option_reg[g] <= OPTION_RST;
        end else if (option_wr[g]) begin
          option_reg[g] <= option_wdata;
        end
      end

      // Edge detect in the selected polarity
      assign now_lvl  = pin_sync[g*LINES +: LINES];
      assign was_lvl  = pin_prev[g*LINES +: LINES];
      assign edge_set = req_polarity_bit ? (now_lvl & ~was_lvl) : (~now_lvl & was_lvl);

      // Request latch: edges always latch, even masked, disarmed or polled
      always_ff @(posedge core_clk) begin
        if (grp_reset) begin
          request_latch[g] <= LATCH_RST;
        end else begin
          // A new edge wins over any clear in the same cycle
          request_latch[g] <= (request_latch[g]
                               & ~(latch_clr[g] ? latch_clr_bits : 8'h00)
                               & ~(take[g] ? (8'h01 << cur_idx_for_take) : 8'h00))
                              | edge_set;
        end
      end

      // Mask register; arm changes never touch it
      always_ff @(posedge core_clk) begin
        if (grp_reset) begin
          mask_bits[g] <= MASK_RST;
        end else if (mask_wr[g]) begin
          mask_bits[g] <= mask_wdata;
        end
      end

      // Auto-clear selection per line
      always_ff @(posedge core_clk) begin
        if (grp_reset) begin
          autoclear_bits[g] <= AUTOCLEAR_RST;
        end else if (autoclear_wr[g]) begin
          autoclear_bits[g] <= autoclear_wdata;
        end
      end

      // In-service bits: an auto-clear line is released before the cycle ends,
      // so it never holds a bit and never builds a fence
      assign svc_set  = take[g] ? ((8'h01 << grp_idx[g]) & ~autoclear_bits[g]) : 8'h00;
      assign svc_clr  = service_clr[g] ? service_clr_bits : 8'h00;
      assign next_svc = (in_service_bits[g] & ~svc_clr) | svc_set;

      always_ff @(posedge core_clk) begin
        if (grp_reset) begin
          in_service_bits[g] <= SERVICE_RST;
        end else begin
          in_service_bits[g] <= next_svc;
        end
      end

      // Selected line of the current service, used for rotation
      always_ff @(posedge core_clk) begin
        if (grp_reset) begin
          cur_sel[g] <= ROT_LAST_RST;
        end else if (take[g]) begin
          cur_sel[g] <= grp_idx[g];
        end
      end

      // Rotation moves when the serviced bit clears; auto-clear lines at once
      always_ff @(posedge core_clk) begin
        if (grp_reset) begin
          rot_last[g] <= ROT_LAST_RST;
        end else if (take[g] && autoclear_bits[g][grp_idx[g]]) begin
          rot_last[g] <= grp_idx[g];
        end else if (in_service_bits[g][cur_sel[g]] && svc_clr[cur_sel[g]]) begin
          rot_last[g] <= cur_sel[g];
        end
      end

      // Fence: fixed admits only lines above the top in-service bit,
      // rotating admits nothing while any bit is set
      always_comb begin
        logic above;
        above = 1'b0;
        for (int i = 0; i < LINES; i++) begin
          above       = above | in_service_bits[g][i];
          fence_ok[i] = ~above;
        end
        if (prio_mode_bit && (|in_service_bits[g])) begin
          fence_ok = 8'h00;
        end
      end

      // Group one's arm bit also disarms group two
      if (g == 0) begin : arm0
        assign armed[g] = group_arm_bit;
      end else begin : armn
        assign armed[g] = group_arm_bit & option_reg[0][ARM_POS];
      end

      // Latched, unmasked, armed, unfenced, interrupt mode
      assign eligible[g] = request_latch[g] & ~mask_bits[g] & fence_ok
                           & {LINES{armed[g] & ~poll_mode_bit}};

      // Fixed order starts at line 0, rotating just after the last serviced
      assign top_pos = prio_mode_bit ? (rot_last[g] + 3'h1) : 3'h0;

      iom_pick u_pick (
        .req     (eligible[g]),
        .top_pos (top_pos),
        .hit     (grp_hit[g]),
        .idx     (grp_idx[g])
      );

      // Group interrupt is forced off in polled mode via eligible
      assign group_irq_out[g] = grp_hit[g];

      // Data port shows the preselected register until reselected
      always_ff @(posedge core_clk) begin
        if (grp_reset) begin
          data_port[g] <= LATCH_RST;
        end else begin
          unique case ({read_select_high, read_select_low})
            SEL_LATCH:     data_port[g] <= request_latch[g];
            SEL_SERVICE:   data_port[g] <= in_service_bits[g];
            SEL_MASK:      data_port[g] <= mask_bits[g];
            SEL_AUTOCLEAR: data_port[g] <= autoclear_bits[g];
          endcase
        end
      end

      // Status view of the option bits and of pending unmasked requests, the register itself is write-only
      assign prio_mode_status[g] = prio_mode_bit;
      assign poll_mode_status[g] = poll_mode_bit;
      assign arm_status[g]       = group_arm_bit;
      assign pending_status[g]   = |(request_latch[g] & ~mask_bits[g]);

      // Index cleared from the latch on acknowledge
      assign cur_idx_for_take = grp_idx[g];
    end
  endgenerate

  assign bus_irq_level4   = |group_irq_out;
  assign group1_data_port = data_port[0];
  assign group2_data_port = data_port[1];

  // Vector fetch: registered, so it lands one cycle after the acknowledge
  logic       vec_common;
  logic [2:0] vec_line;

  assign vec_common = option_reg[ack_grp][VECTOR_MODE_POS];
  assign vec_line   = vec_common ? COMMON_LINE : ack_idx;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      vector_out   <= VECTOR_RST;
      vector_valid <= 1'b0;
      vector_group <= 1'b0;
    end else begin
      vector_valid <= ack_take;
      if (ack_take) begin
        vector_out   <= vec_mem[{ack_grp, vec_line}];
        vector_group <= ack_grp;
      end
    end
  end

endmodule : iom_ctrl
`default_nettype wire

// *** hdl/iom_ctrl_note.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** hdl/iom_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
// Circular priority picker: scans from top_pos upward, wrapping
module iom_pick
  import iom_pkg::*;
(
  input  wire logic [7:0] req,
  input  wire logic [2:0] top_pos,
  output logic            hit,
  output logic [2:0]      idx
);

  // First pending request met going round from the top position
  always_comb begin
    logic [2:0] pos;
    pos = 3'h0;
    hit = 1'b0;
    idx = 3'h0;
    for (int k = LINES - 1; k >= 0; k--) begin
      pos = top_pos + 3'(k);
      if (req[pos]) begin
        hit = 1'b1;
        idx = pos;
      end
    end
  end

endmodule : iom_pick
`default_nettype wire

// *** hdl/iom_pkg.sv ***
// How it works
// - Fixed mode: group one level 0 highest.
// - Rotating mode: last serviced input goes lowest.
// - Rotation per group; group one always above.
// - Acknowledge picks top request, drives its vector.
// - Rotating: any in-service bit blocks all interrupts of its own group.
// - Rotation order updates when in-service bit clears.
// - Individual vector: each line its own vector.
// - Common vector: line 0 vector always used.
// - Poll bit zero: interrupts enabled.
// - Poll bit one: group interrupt held inactive.
// - Polled: latch and mask only, no service.
// - Polarity bit picks falling or rising edge.
// - Read-select bits choose data port read source.
// - Read selection holds until rewritten.
// - Arm zero: latch inputs, forward nothing.
// - Arm one: unmasked requests may interrupt.
// - Arm changes leave mask bits untouched.
// - Group one arm gates both groups.
// - Any reset clears all option bits.
// - Priority, poll, arm bits visible as status.
// - Mask zero enables input, one disables.
// - Fixed: in-service fence admits only higher requests.
package iom_pkg;

  localparam int GROUPS = 2;
  localparam int LINES  = 8;

  // Option register field positions
  localparam int PRIO_MODE_POS   = 0;
  localparam int VECTOR_MODE_POS = 1;
  localparam int POLL_MODE_POS   = 2;
  localparam int UNUSED_POS      = 3;
  localparam int POLARITY_POS    = 4;
  localparam int RD_SEL_LOW_POS  = 5;
  localparam int RD_SEL_HIGH_POS = 6;
  localparam int ARM_POS         = 7;

  // Values after reset
  localparam logic [7:0] OPTION_RST    = 8'h00;
  localparam logic [7:0] MASK_RST      = 8'hff;
  localparam logic [7:0] LATCH_RST     = 8'h00;
  localparam logic [7:0] SERVICE_RST   = 8'h00;
  localparam logic [7:0] AUTOCLEAR_RST = 8'h00;
  localparam logic [7:0] VECTOR_RST    = 8'h00;
  // Last serviced position 7 makes position 0 the top, same as fixed order
  localparam logic [2:0] ROT_LAST_RST  = 3'h7;

  // Read-select codes, {read_select_high, read_select_low}
  localparam logic [1:0] SEL_LATCH     = 2'h0;
  localparam logic [1:0] SEL_SERVICE   = 2'h1;
  localparam logic [1:0] SEL_MASK      = 2'h2;
  localparam logic [1:0] SEL_AUTOCLEAR = 2'h3;

  // Common vector mode reads the location of line 0
  localparam logic [2:0] COMMON_LINE   = 3'h0;

endpackage : iom_pkg

// *** test/iom_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the interrupt request and acknowledge outputs
module iom_chk (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       ack_cycle,
  input wire logic       vector_valid,
  input wire logic       vector_group,
  input wire logic [1:0] group_irq_out,
  input wire logic       bus_irq_level4,
  input wire logic [1:0] prio_mode_status,
  input wire logic [1:0] poll_mode_status,
  input wire logic [1:0] arm_status,
  input wire logic [1:0] pending_status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  a_ack_answer: assert property (ack_cycle && bus_irq_level4 |=> vector_valid)
    else $error("no vector after acknowledge");
  a_ack_refused: assert property (!(ack_cycle && bus_irq_level4) |=> !vector_valid)
    else $error("vector without accepted acknowledge");
  a_group_one_first: assert property (ack_cycle && group_irq_out[0] |=> !vector_group)
    else $error("group two served ahead of group one");
  a_group_two_served: assert property (ack_cycle && group_irq_out == 2'b10 |=> vector_group)
    else $error("group two request not served");
  a_poll_quiet: assert property ((poll_mode_status & group_irq_out) == 2'b00)
    else $error("interrupt raised in polled mode");
  a_master_disarm: assert property (!arm_status[0] |-> group_irq_out == 2'b00)
    else $error("interrupt while group one disarmed");
  a_group_disarm: assert property (!arm_status[1] |-> !group_irq_out[1])
    else $error("group two interrupt while disarmed");
  a_mask_gate: assert property ((group_irq_out & ~pending_status) == 2'b00)
    else $error("interrupt without unmasked request");
  a_bus_request: assert property (bus_irq_level4 == (|group_irq_out))
    else $error("bus request disagrees with groups");
  a_reset_clears: assert property (disable iff (1'b0)
      srst |=> (prio_mode_status | poll_mode_status | arm_status) == 2'b00)
    else $error("option bits survive reset");
endmodule : iom_chk

bind iom_ctrl iom_chk u_chk (.core_clk, .srst, .ack_cycle, .vector_valid, .vector_group, .group_irq_out,
  .bus_irq_level4, .prio_mode_status, .poll_mode_status, .arm_status, .pending_status);
`default_nettype wire

// *** test/iom_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module iom_ctrl_test;
  import iom_pkg::*;
  logic        core_clk, srst, vec_wr, host_en, host_slow, ack_cycle, vector_valid, vector_group, bus_irq_level4;
  logic [15:0] irq_pin;
  logic [3:0]  vec_waddr;
  logic [1:0]  soft_reset, option_wr, mask_wr, autoclear_wr, latch_clr, service_clr, group_irq_out;
  logic [1:0]  prio_mode_status, poll_mode_status, arm_status, pending_status;
  logic [7:0]  option_wdata, mask_wdata, autoclear_wdata, latch_clr_bits, service_clr_bits, vec_wdata;
  logic [7:0]  vector_out, group1_data_port, group2_data_port;
  logic [7:0]  exp_tab [4];
  int          n_mismatch, check_count, cyc;

  iom_ctrl u_dut (.core_clk, .srst, .irq_pin, .soft_reset, .option_wr, .option_wdata, .mask_wr, .mask_wdata,
    .autoclear_wr, .autoclear_wdata, .latch_clr, .latch_clr_bits, .service_clr, .service_clr_bits, .vec_wr,
    .vec_waddr, .vec_wdata, .ack_cycle, .vector_out, .vector_valid, .vector_group, .group_irq_out,
    .bus_irq_level4, .group1_data_port, .group2_data_port, .prio_mode_status, .poll_mode_status,
    .arm_status, .pending_status);
  iom_host u_host (.core_clk, .srst, .en(host_en), .slow(host_slow), .bus_irq_level4, .ack_cycle);

  // Clock and a hang guard well above the few hundred cycles needed
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Kinds: 0 option, 1 mask, 2 auto-clear, 3 latch clear, 4 service clear, 5 soft reset
  task automatic cmd(input int k, input logic [1:0] g, input logic [7:0] d);
    case (k)
      0: begin option_wr = g; option_wdata = d; end
      1: begin mask_wr = g; mask_wdata = d; end
      2: begin autoclear_wr = g; autoclear_wdata = d; end
      3: begin latch_clr = g; latch_clr_bits = d; end
      4: begin service_clr = g; service_clr_bits = d; end
      default: soft_reset = g;
    endcase
    step(1);
    {option_wr, mask_wr, autoclear_wr, latch_clr, service_clr, soft_reset} = '0;
    step(1);
  endtask : cmd

  // Pulse a pin away from idle and back, then let the synchroniser settle
  task automatic fire(input int i);
    irq_pin[i] = ~irq_pin[i];
    step(3);
    irq_pin[i] = ~irq_pin[i];
    step(4);
  endtask : fire

  task automatic ack(input logic [7:0] v, input logic gr);
    host_en = 1'b1;
    for (int i = 0; i < 20 && vector_valid !== 1'b1; i++) step(1);
    host_en = 1'b0;
    chk(vector_out, v);
    chk({7'h0, vector_group}, {7'h0, gr});
    step(1);
  endtask : ack

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // Main sequence; vector memory holds 40h plus {group,line}
  initial begin
    {srst, irq_pin} = {1'b1, 16'hffff};
    {vec_wr, host_en, host_slow, vec_waddr, vec_wdata} = '0;
    {soft_reset, option_wr, mask_wr, autoclear_wr, latch_clr, service_clr} = '0;
    {option_wdata, mask_wdata, autoclear_wdata, latch_clr_bits, service_clr_bits} = '0;
    repeat (8) @(posedge core_clk);
    #1 srst = 1'b0;
    for (int a = 0; a < 16; a++) begin
      vec_wr = 1'b1;
      vec_waddr = a[3:0];
      vec_wdata = 8'h40 + 8'(a);
      step(1);
    end
    vec_wr = 1'b0;
    chk({prio_mode_status, poll_mode_status, arm_status, 2'h0}, 8'h00);
    cmd(0, 2'h1, 8'h40);
    chk(group1_data_port, 8'hff);
    // Polled mode latches but never interrupts
    cmd(1, 2'h3, 8'h00);
    cmd(0, 2'h1, 8'h85);
    chk({prio_mode_status, poll_mode_status, arm_status, 2'h0}, 8'h54);
    fire(3);
    chk(group1_data_port, 8'h08);
    chk({pending_status, group_irq_out, 4'h0}, 8'h40);
    cmd(3, 2'h1, 8'h08);
    chk(group1_data_port, 8'h00);
    // Fixed order across groups, fence holds lower lines
    cmd(0, 2'h3, 8'h80);
    fire(5);
    fire(2);
    fire(8);
    ack(8'h42, 1'b0);
    chk({6'h0, group_irq_out}, 8'h02);
    ack(8'h48, 1'b1);
    cmd(4, 2'h1, 8'h04);
    ack(8'h45, 1'b0);
    cmd(4, 2'h3, 8'h21);
    // Common vector
    cmd(0, 2'h1, 8'h82);
    fire(6);
    ack(8'h40, 1'b0);
    cmd(4, 2'h1, 8'h40);
    // Disarming group one silences both, mask survives
    cmd(0, 2'h1, 8'h00);
    fire(3);
    fire(9);
    chk({pending_status, group_irq_out, 4'h0}, 8'hc0);
    cmd(0, 2'h1, 8'hc0);
    chk(group1_data_port, 8'h00);
    chk({6'h0, group_irq_out}, 8'h03);
    cmd(3, 2'h3, 8'hff);
    chk({7'h0, bus_irq_level4}, 8'h00);
    // Rising polarity ignores a falling pin
    cmd(0, 2'h2, 8'h90);
    irq_pin[9] = 1'b0;
    step(4);
    chk(group2_data_port, 8'h00);
    irq_pin[9] = 1'b1;
    step(4);
    chk(group2_data_port, 8'h02);
    cmd(3, 2'h2, 8'h02);
    // Every read-select code, then selection persists across writes
    cmd(1, 2'h2, 8'h3c);
    cmd(2, 2'h2, 8'h5a);
    exp_tab = '{8'h00, 8'h00, 8'h3c, 8'h5a};
    for (int c = 0; c < 4; c++) begin
      cmd(0, 2'h2, {1'b0, c[1:0], 5'h10});
      chk(group2_data_port, exp_tab[c]);
    end
    cmd(1, 2'h2, 8'h81);
    cmd(2, 2'h2, 8'h33);
    chk(group2_data_port, 8'h33);
    // Rotation puts the serviced line last
    cmd(5, 2'h1, 8'h00);
    chk({prio_mode_status, poll_mode_status, arm_status, 2'h0}, 8'h00);
    cmd(1, 2'h1, 8'h00);
    cmd(0, 2'h1, 8'h81);
    fire(4);
    fire(1);
    ack(8'h41, 1'b0);
    chk({6'h0, group_irq_out}, 8'h00);
    cmd(4, 2'h1, 8'h02);
    fire(0);
    host_slow = 1'b1;
    ack(8'h44, 1'b0);
    stop_test();
  end
endmodule : iom_ctrl_test
`default_nettype wire

// *** test/iom_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Processor side: answers a group interrupt with one acknowledge pulse
module iom_host (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic en,
  input  wire logic slow,
  input  wire logic bus_irq_level4,
  output logic      ack_cycle
);
  logic [1:0] wait_cnt;

  // A slow processor finishes its instruction first, so the request may vanish meanwhile
  always_ff @(posedge core_clk) begin
    if (srst || !en || !bus_irq_level4) begin
      ack_cycle <= 1'b0;
      wait_cnt  <= slow ? 2'h3 : 2'h0;
    end else if (ack_cycle) begin
      ack_cycle <= 1'b0;
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
    end else begin
      ack_cycle <= 1'b1;
    end
  end
endmodule : iom_host
`default_nettype wire
